// File: hw/touch_key_detect_engine.sv
// What this block does
// - Reference steps down one count per negative drift interval, 0.25 s units
// - Reference steps up one count every fixed 0.4 s
// - Raised signal after removed object pulls reference up quickly
// - Key counts as enabled only with non-zero normal confirm limit
// - Disabled keys are skipped entirely by the scan sequence
// - On first touch stay on key bursting until fast limit or failure
// - Each key has own fast counter and fast limit of 1 to 15
// - Normal counter bumps once per visit; key active at normal limit
// - Fast counter increments at or below threshold, clears above it
// - Fast limit of one gives single burst per rotation
// - Long continuous detection recalibrates key after negative delay
// - Negative delay byte: zero never, else 0.5 s steps
// - Signal above release threshold for 1 s recalibrates key
// - Burst pulses X line per cycle while Y line enabled
// - Burst length is 16, 32, 48 or 64 cycles, default 48
// - Suppressed key loses detection if other suppression-enabled key deviates more
// - Suppression compares raw deviations only
// - Suppression off per key after reset, enabled by setup
// - Drift compensation frozen while signal is past touch threshold
// - Touch threshold is setting plus four below the reference
// - Two-bit burst code maps through lookup, code 2 gives 48
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module touch_key_detect_engine #(
  parameter int TICK_CYCLES = touch_key_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [6:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  // Matrix drive
  output logic [7:0] xDrive,
  output logic [2:0] yEnable,
  output logic convStart,
  // Converter result
  input wire logic convDone,
  input wire logic [11:0] convValue,
  // Key results
  output logic [23:0] keyDetect
);

  // ***************************************
  // Reset release
  // ***************************************
  logic rstMeta_reg;
  logic rstSync_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_reg);

  // ***************************************
  // Time base
  // ***************************************
  logic [31:0] tickDiv_reg;
  logic [15:0] tickNow_reg;
  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      tickDiv_reg <= 32'h0000_0000;
      tickNow_reg <= 16'h0000;
    end else if (tickDiv_reg == 32'(TICK_CYCLES - 1)) begin
      tickDiv_reg <= 32'h0000_0000;
      tickNow_reg <= tickNow_reg + 16'h0001;
    end else begin
      tickDiv_reg <= tickDiv_reg + 32'h0000_0001;
    end
  end

  // ***************************************
  // Register bus
  // ***************************************
  logic [31:0] cfg_reg [touch_key_pkg::KEYS];
  logic ack_reg;
  logic [31:0] readdata_reg;
  logic [23:0] keyDetect_reg;
  logic [23:0] enabledMask;
  logic [4:0] wordIdx;

  assign wordIdx = avsAddress[6:2];
  assign avsWaitrequest = (avsRead | avsWrite) & ~ack_reg;
  assign avsReaddata = readdata_reg;

  always_comb begin
    for (int k = 0; k < touch_key_pkg::KEYS; k++) begin
      enabledMask[k] = touch_key_pkg::nlimOf(cfg_reg[k]) != 4'h0;
    end
  end

  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= (avsRead | avsWrite) & ~ack_reg;
      if (avsRead && !ack_reg) begin
        if (avsAddress == touch_key_pkg::ADDR_DETECT) begin
          readdata_reg <= {8'h00, keyDetect_reg};
        end else if (avsAddress == touch_key_pkg::ADDR_ENABLED) begin
          readdata_reg <= {8'h00, enabledMask};
        end else if (int'(wordIdx) < touch_key_pkg::KEYS) begin
          readdata_reg <= cfg_reg[wordIdx];
        end else begin
          readdata_reg <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      for (int k = 0; k < touch_key_pkg::KEYS; k++) begin
        cfg_reg[k] <= touch_key_pkg::CFG_RESET;
      end
    end else if (avsWrite && ack_reg && int'(wordIdx) < touch_key_pkg::KEYS) begin
      for (int b = 0; b < 4; b++) begin
        if (avsByteenable[b]) begin
          cfg_reg[wordIdx][b*8 +: 8] <= avsWritedata[b*8 +: 8];
        end
      end
    end
  end

  // ***************************************
  // Scan sequencer
  // ***************************************
  typedef enum logic [2:0] {
    ST_SELECT, ST_PULSE_HI, ST_PULSE_LO, ST_CONVERT, ST_WAIT, ST_PROCESS
  } scan_state_e;

  scan_state_e state_reg;
  logic [4:0] curKey_reg;
  logic [6:0] pulseCnt_reg;
  logic [6:0] burstLen_reg;
  logic [11:0] sample_reg;
  logic stayKey;

  function automatic logic [4:0] nextKey(input logic [4:0] cur,
                                         input logic [23:0] mask);
    logic [4:0] pick;
    int idx;
    pick = cur;
    for (int i = touch_key_pkg::KEYS; i >= 1; i--) begin
      idx = (int'(cur) + i) % touch_key_pkg::KEYS;
      if (mask[idx]) begin
        pick = 5'(idx);
      end
    end
    return pick;
  endfunction

  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      state_reg <= ST_SELECT;
      curKey_reg <= 5'h17;
      pulseCnt_reg <= 7'h00;
      burstLen_reg <= 7'h00;
      sample_reg <= 12'h000;
    end else begin
      unique case (state_reg)
        ST_SELECT: begin
          if (|enabledMask) begin
            curKey_reg <= nextKey(curKey_reg, enabledMask);
            pulseCnt_reg <= 7'h00;
            state_reg <= ST_PULSE_HI;
          end
        end
        ST_PULSE_HI: begin
          pulseCnt_reg <= pulseCnt_reg + 7'h01;
          if (pulseCnt_reg == 7'h00) begin
            burstLen_reg <=
              touch_key_pkg::burstCycles(cfg_reg[curKey_reg]);
          end
          state_reg <= ST_PULSE_LO;
        end
        ST_PULSE_LO: begin
          if (pulseCnt_reg >= burstLen_reg) begin
            state_reg <= ST_CONVERT;
          end else begin
            state_reg <= ST_PULSE_HI;
          end
        end
        ST_CONVERT: state_reg <= ST_WAIT;
        ST_WAIT: begin
          if (convDone) begin
            sample_reg <= convValue;
            state_reg <= ST_PROCESS;
          end
        end
        ST_PROCESS: begin
          pulseCnt_reg <= 7'h00;
          state_reg <= stayKey ? ST_PULSE_HI : ST_SELECT;
        end
      endcase
    end
  end

  // Charge-transfer cycle drive
  always_comb begin
    xDrive = 8'h00;
    yEnable = 3'h0;
    if (state_reg == ST_PULSE_HI) begin
      xDrive[curKey_reg[2:0]] = 1'b1;
    end
    if (state_reg inside {ST_PULSE_HI, ST_PULSE_LO, ST_CONVERT}) begin
      yEnable[curKey_reg[4:3]] = 1'b1;
    end
  end
  assign convStart = state_reg == ST_CONVERT;

  // ***************************************
  // Per-key state
  // ***************************************
  logic [11:0] ref_reg [touch_key_pkg::KEYS];
  logic [11:0] dev_reg [touch_key_pkg::KEYS];
  logic [3:0] fast_reg [touch_key_pkg::KEYS];
  logic [3:0] norm_reg [touch_key_pkg::KEYS];
  logic [15:0] detStamp_reg [touch_key_pkg::KEYS];
  logic [15:0] posStamp_reg [touch_key_pkg::KEYS];
  logic [15:0] driftStamp_reg [touch_key_pkg::KEYS];
  logic [23:0] active_reg;
  logic [23:0] calDone_reg;
  logic [23:0] detFlag_reg;
  logic [23:0] posFlag_reg;

  // ***************************************
  // Burst evaluation
  // ***************************************
  logic [31:0] cfgCur;
  logic [11:0] refCur;
  logic [4:0] thrCur;
  logic [3:0] fastLim;
  logic [3:0] fastNext;
  logic [7:0] negTicks;
  logic [15:0] negRecalTicks;
  logic [15:0] detEl;
  logic [15:0] posEl;
  logic [15:0] driftEl;
  logic below;
  logic posExc;
  logic fastHit;
  logic recal;
  logic driftRestart;
  logic [11:0] refNew;
  logic doProc;

  always_comb begin
    cfgCur = cfg_reg[curKey_reg];
    refCur = ref_reg[curKey_reg];
    thrCur = {1'b0, touch_key_pkg::thrOf(cfgCur)} +
             touch_key_pkg::THR_OFFSET;
    below = {1'b0, sample_reg} + {8'h00, thrCur} <= {1'b0, refCur};
    posExc = {1'b0, sample_reg} >=
             {1'b0, refCur} + {1'b0, touch_key_pkg::RELEASE_THR};
    fastLim = touch_key_pkg::flimOf(cfgCur);
    if (fastLim == 4'h0) begin
      fastLim = 4'h1;
    end
    fastNext = fast_reg[curKey_reg] + 4'h1;
    fastHit = below && fastNext >= fastLim;
    negTicks = 8'(touch_key_pkg::driftOf(cfgCur)) *
               8'(touch_key_pkg::NEG_DRIFT_UNIT_TICKS);
    negRecalTicks = 16'(touch_key_pkg::negRecalOf(cfgCur)) *
                    16'(touch_key_pkg::NEG_RECAL_UNIT_TICKS);
    detEl = tickNow_reg - detStamp_reg[curKey_reg];
    posEl = tickNow_reg - posStamp_reg[curKey_reg];
    driftEl = tickNow_reg - driftStamp_reg[curKey_reg];
    recal = !calDone_reg[curKey_reg]
      || (below && detFlag_reg[curKey_reg] && negRecalTicks != 16'h0000
          && detEl > negRecalTicks)
      || (posExc && posFlag_reg[curKey_reg]
          && posEl >= 16'(touch_key_pkg::POS_RECAL_TICKS));
    if (recal) begin
      refNew = sample_reg;
    end else if (below) begin
      refNew = refCur;
    end else if (sample_reg < refCur && driftEl >= {8'h00, negTicks}) begin
      refNew = refCur - 12'h001;
    end else if (sample_reg > refCur &&
                 driftEl >= 16'(touch_key_pkg::POS_DRIFT_TICKS)) begin
      refNew = refCur + 12'h001;
    end else begin
      refNew = refCur;
    end
    driftRestart = recal || below || refNew != refCur || sample_reg == refCur;
    stayKey = below && !fastHit && !recal;
    doProc = state_reg == ST_PROCESS;
  end

  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      calDone_reg <= 24'h00_0000;
      for (int k = 0; k < touch_key_pkg::KEYS; k++) begin
        ref_reg[k] <= 12'h000;
        dev_reg[k] <= 12'h000;
      end
    end else if (doProc) begin
      calDone_reg[curKey_reg] <= 1'b1;
      ref_reg[curKey_reg] <= refNew;
      dev_reg[curKey_reg] <= refCur > sample_reg ?
                             refCur - sample_reg : 12'h000;
    end
  end

  // Confirmation counters
  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      active_reg <= 24'h00_0000;
      for (int k = 0; k < touch_key_pkg::KEYS; k++) begin
        fast_reg[k] <= 4'h0;
        norm_reg[k] <= 4'h0;
      end
    end else if (doProc) begin
      if (recal || !below) begin
        fast_reg[curKey_reg] <= 4'h0;
        norm_reg[curKey_reg] <= 4'h0;
        active_reg[curKey_reg] <= 1'b0;
      end else if (fastHit) begin
        fast_reg[curKey_reg] <= 4'h0;
        if (norm_reg[curKey_reg] < touch_key_pkg::nlimOf(cfgCur)) begin
          norm_reg[curKey_reg] <= norm_reg[curKey_reg] + 4'h1;
        end
        if (norm_reg[curKey_reg] + 4'h1 >= touch_key_pkg::nlimOf(cfgCur)) begin
          active_reg[curKey_reg] <= 1'b1;
        end
      end else begin
        fast_reg[curKey_reg] <= fastNext;
      end
    end
  end

  // Excursion and drift timers
  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      detFlag_reg <= 24'h00_0000;
      posFlag_reg <= 24'h00_0000;
      for (int k = 0; k < touch_key_pkg::KEYS; k++) begin
        detStamp_reg[k] <= 16'h0000;
        posStamp_reg[k] <= 16'h0000;
        driftStamp_reg[k] <= 16'h0000;
      end
    end else if (doProc) begin
      if (recal || !below) begin
        detFlag_reg[curKey_reg] <= 1'b0;
      end else if (!detFlag_reg[curKey_reg]) begin
        detFlag_reg[curKey_reg] <= 1'b1;
        detStamp_reg[curKey_reg] <= tickNow_reg;
      end
      if (recal || !posExc) begin
        posFlag_reg[curKey_reg] <= 1'b0;
      end else if (!posFlag_reg[curKey_reg]) begin
        posFlag_reg[curKey_reg] <= 1'b1;
        posStamp_reg[curKey_reg] <= tickNow_reg;
      end
      if (driftRestart) begin
        driftStamp_reg[curKey_reg] <= tickNow_reg;
      end
    end
  end

  // ***************************************
  // Neighbour suppression
  // ***************************************
  logic [23:0] detectNext;
  always_comb begin
    for (int i = 0; i < touch_key_pkg::KEYS; i++) begin
      detectNext[i] = active_reg[i] & enabledMask[i];
      for (int j = 0; j < touch_key_pkg::KEYS; j++) begin
        if (j != i && touch_key_pkg::suppressOf(cfg_reg[i]) &&
            touch_key_pkg::suppressOf(cfg_reg[j]) &&
            dev_reg[j] > dev_reg[i]) begin
          detectNext[i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      keyDetect_reg <= 24'h00_0000;
    end else begin
      keyDetect_reg <= detectNext;
    end
  end
  assign keyDetect = keyDetect_reg;

  // ***************************************
  // Checks
  // ***************************************
  logic [6:0] pulsesSeen_reg;
  logic [23:0] enabledPrev_reg;
  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      pulsesSeen_reg <= 7'h00;
      enabledPrev_reg <= 24'h00_0000;
    end else begin
      enabledPrev_reg <= enabledMask;
      if (state_reg inside {ST_SELECT, ST_PROCESS}) begin
        pulsesSeen_reg <= 7'h00;
      end else if (|xDrive) begin
        pulsesSeen_reg <= pulsesSeen_reg + 7'h01;
      end
    end
  end

  AST_BURST_LEN: assert property (
    convStart |-> pulsesSeen_reg == burstLen_reg)
    else $error("burst length wrong");
  AST_Y_WITH_X: assert property (
    (|xDrive) |-> yEnable[curKey_reg[4:3]] && $onehot(xDrive))
    else $error("X pulse without Y capture");
  AST_SKIP_DISABLED: assert property (
    (state_reg == ST_SELECT && (|enabledMask)) |=>
      enabledPrev_reg[curKey_reg])
    else $error("disabled key scanned");
  AST_FAST_STAY: assert property (
    (doProc && stayKey) |=> state_reg == ST_PULSE_HI && $stable(curKey_reg))
    else $error("left key during fast burst");
  AST_FAST_LEAVE: assert property (
    (doProc && !stayKey) |=> state_reg == ST_SELECT)
    else $error("stayed on key after fast end");
  AST_FREEZE: assert property (
    (doProc && below && !recal) |=> ref_reg[curKey_reg] == $past(refCur))
    else $error("reference moved during detection");
  AST_DRIFT_STEP: assert property (
    (doProc && !recal) |=> ref_reg[curKey_reg] == $past(refCur) ||
      ref_reg[curKey_reg] == $past(refCur) + 12'h001 ||
      ref_reg[curKey_reg] == $past(refCur) - 12'h001)
    else $error("drift step larger than one");
  AST_RECAL_CLEAR: assert property (
    (doProc && recal) |=> fast_reg[curKey_reg] == 4'h0 &&
      norm_reg[curKey_reg] == 4'h0 && !active_reg[curKey_reg] ##1
      !keyDetect_reg[$past(curKey_reg, 2)])
    else $error("recalibration left state");
  AST_FAST_CLEAR: assert property (
    (doProc && !below) |=> fast_reg[curKey_reg] == 4'h0)
    else $error("fast counter not cleared");
  AST_ACTIVE_SET: assert property (
    (doProc && fastHit && !recal &&
     norm_reg[curKey_reg] + 4'h1 >= touch_key_pkg::nlimOf(cfgCur))
      |=> active_reg[curKey_reg])
    else $error("key not activated at normal limit");
  AST_BUS_ANSWER: assert property (
    ((avsRead || avsWrite) && avsWaitrequest) |=> !avsWaitrequest)
    else $error("bus answer late");

  COV_FAST_STAY: cover property (doProc && stayKey ##[2:300] doProc);
  COV_RECAL: cover property (doProc && recal && calDone_reg[curKey_reg]);
  COV_DETECT: cover property (|keyDetect_reg);
  COV_SUPPRESS: cover property (|(active_reg & enabledMask & ~detectNext));

endmodule
`default_nettype wire

// File: shared/touch_key_pkg.sv
`default_nettype none
package touch_key_pkg;

  // ***************************************
  // Matrix geometry and widths
  // ***************************************
  localparam int KEYS = 24;
  localparam int X_LINES = 8;
  localparam int Y_LINES = 3;
  localparam int SIG_W = 12;
  localparam int STAMP_W = 16;

  // ***************************************
  // Timing
  // ***************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 50;
  localparam int TICK_CYCLES = TICK_MS * (CLK_HZ / 1000);
  localparam int NEG_DRIFT_UNIT_MS = 250;
  localparam int NEG_DRIFT_UNIT_TICKS = NEG_DRIFT_UNIT_MS / TICK_MS;
  localparam int POS_DRIFT_MS = 400;
  localparam int POS_DRIFT_TICKS = POS_DRIFT_MS / TICK_MS;
  localparam int NEG_RECAL_UNIT_MS = 500;
  localparam int NEG_RECAL_UNIT_TICKS = NEG_RECAL_UNIT_MS / TICK_MS;
  localparam int POS_RECAL_MS = 1000;
  localparam int POS_RECAL_TICKS = POS_RECAL_MS / TICK_MS;

  // ***************************************
  // Thresholds
  // ***************************************
  localparam logic [4:0] THR_OFFSET = 5'h04;
  localparam logic [SIG_W-1:0] RELEASE_THR = 12'h006;

  // ***************************************
  // Register map and fields
  // ***************************************
  localparam int ADDR_W = 7;
  localparam logic [ADDR_W-1:0] ADDR_DETECT = 7'h60;
  localparam logic [ADDR_W-1:0] ADDR_ENABLED = 7'h64;
  localparam int THR_LSB = 0;
  localparam int DRIFT_LSB = 4;
  localparam int NLIM_LSB = 8;
  localparam int FLIM_LSB = 12;
  localparam int NEG_RECAL_LSB = 16;
  localparam int BURST_LSB = 28;
  localparam int SUPPRESS_BIT = 30;
  localparam logic [31:0] CFG_RESET = 32'h2014_52A6;

  // ***************************************
  // Field decode
  // ***************************************
  function automatic logic [3:0] thrOf(input logic [31:0] w);
    return w[THR_LSB +: 4];
  endfunction
  function automatic logic [3:0] driftOf(input logic [31:0] w);
    return w[DRIFT_LSB +: 4];
  endfunction
  function automatic logic [3:0] nlimOf(input logic [31:0] w);
    return w[NLIM_LSB +: 4];
  endfunction
  function automatic logic [3:0] flimOf(input logic [31:0] w);
    return w[FLIM_LSB +: 4];
  endfunction
  function automatic logic [7:0] negRecalOf(input logic [31:0] w);
    return w[NEG_RECAL_LSB +: 8];
  endfunction
  function automatic logic suppressOf(input logic [31:0] w);
    return w[SUPPRESS_BIT];
  endfunction
  function automatic logic [6:0] burstCycles(input logic [31:0] w);
    logic [6:0] n;
    unique case (w[BURST_LSB +: 2])
      2'h0: n = 7'h10;
      2'h1: n = 7'h20;
      2'h2: n = 7'h30;
      2'h3: n = 7'h40;
    endcase
    return n;
  endfunction

endpackage
`default_nettype wire

// File: tb/touch_matrix_model.sv
`timescale 1ns/1ps
`default_nettype none
module touch_matrix_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Matrix lines
  input wire logic [7:0] xDrive,
  input wire logic [2:0] yEnable,
  input wire logic convStart,
  output logic convDone,
  output logic [11:0] convValue,
  // Bench side
  input wire logic [11:0] keySig [24],
  input wire logic clrVisit,
  output logic [6:0] pulseOf [24],
  output logic [23:0] visited,
  output logic [3:0] maxRun
);
  logic [4:0] key;
  logic [4:0] cur;
  logic [4:0] last;
  logic [6:0] pulses;
  logic [3:0] run;
  logic [3:0] nextRun;
  logic [2:0] waitCnt;
  assign nextRun = (cur == last) ? run + 4'h1 : 4'h1;
  always_comb begin
    key = 5'h00;
    for (int i = 0; i < 8; i++)
      if (xDrive[i]) key[2:0] = 3'(i);
    for (int i = 0; i < 3; i++)
      if (yEnable[i]) key[4:3] = 2'(i);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      convDone <= 1'b0;
      convValue <= 12'h000;
      cur <= 5'h00;
      last <= 5'h1F;
      pulses <= 7'h00;
      run <= 4'h0;
      waitCnt <= 3'h0;
      visited <= 24'h000000;
      maxRun <= 4'h0;
      pulseOf <= '{default: 7'h00};
    end else begin
      convDone <= 1'b0;
      convValue <= ~convValue;
      if (clrVisit) begin
        visited <= 24'h000000;
        maxRun <= 4'h0;
      end
      if (xDrive != 8'h00 && yEnable != 3'h0) begin
        pulses <= pulses + 7'h01;
        cur <= key;
      end
      if (convStart) begin
        pulseOf[cur] <= pulses;
        pulses <= 7'h00;
        visited[cur] <= 1'b1;
        last <= cur;
        run <= nextRun;
        if (nextRun > maxRun)
          maxRun <= nextRun;
        waitCnt <= cur[0] ? 3'h5 : 3'h1;
      end else if (waitCnt != 3'h0) begin
        waitCnt <= waitCnt - 3'h1;
        if (waitCnt == 3'h1) begin
          convDone <= 1'b1;
          convValue <= keySig[cur];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/touch_key_detect_engine_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module touch_key_detect_engine_tb_top;
  localparam logic [11:0] BASE = 12'h400;
  localparam logic [31:0] CFG = 32'h0014_52A7;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] avsAddress = 7'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [3:0] avsByteenable = 4'hF;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic [7:0] xDrive;
  logic [2:0] yEnable;
  logic convStart;
  logic convDone;
  logic [11:0] convValue;
  logic [23:0] keyDetect;
  logic [11:0] keySig [24];
  logic clrVisit = 1'b0;
  logic [6:0] pulseOf [24];
  logic [23:0] visited;
  logic [3:0] maxRun;
  logic [23:0] enMask = 24'hFFFFFF;
  logic [31:0] rd;
  int nErrors = 0;
  int nCompared = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  touch_key_detect_engine #(.TICK_CYCLES(50)) i_dut (.clk, .rst_n,
    .avsAddress, .avsRead, .avsWrite, .avsWritedata, .avsByteenable,
    .avsReaddata, .avsWaitrequest, .xDrive, .yEnable, .convStart,
    .convDone, .convValue, .keyDetect);
  touch_matrix_model i_model (.clk, .rst_n, .xDrive, .yEnable,
    .convStart, .convDone, .convValue, .keySig, .clrVisit, .pulseOf,
    .visited, .maxRun);
  task automatic stopTest();
    if (nErrors == 0 && nCompared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      nErrors++;
      stopTest();
    end
  end
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [6:0] a,
      input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge clk);
      t++;
    end while (avsWaitrequest !== 1'b0 && t < 50);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    check("waitrequest", 32'h0, 32'(avsWaitrequest));
  endtask
  task automatic rdChk(input logic [6:0] a, input logic [31:0] exp,
      input string what);
    bus(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask
  task automatic waitScan(input int n);
    int t;
    repeat (n) begin
      @(posedge clk);
      clrVisit <= 1'b1;
      @(posedge clk);
      clrVisit <= 1'b0;
      @(posedge clk);
      t = 0;
      while (visited !== enMask && t < 5000) begin
        @(posedge clk);
        t++;
      end
      check("visited", 32'(enMask), 32'(visited));
    end
  endtask
  task automatic waitKey(input int k, input logic v, input int lim);
    int t;
    t = 0;
    while (keyDetect[k] !== v && t < lim) begin
      @(posedge clk);
      t++;
    end
    check("keyDetect bit", 32'(v), 32'(keyDetect[k]));
  endtask
  initial begin
    for (int i = 0; i < 24; i++)
      keySig[i] = BASE;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdChk(7'h00, touch_key_pkg::CFG_RESET, "setup");
    rdChk(touch_key_pkg::ADDR_ENABLED, 32'(enMask), "en");
    bus(1'b1, 7'h70, 32'hFFFF_FFFF);
    rdChk(7'h70, 32'h0, "unmapped");
    waitScan(1);
    check("burst", 32'h30, 32'(pulseOf[0]));
    for (int k = 0; k < 24; k++)
      bus(1'b1, 7'(4 * k), CFG);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 7'h00, CFG | (32'(c) << 28));
      waitScan(2);
      check("burst", 32'(16 * (c + 1)), 32'(pulseOf[0]));
    end
    bus(1'b1, 7'h14, CFG & ~32'h0000_0F00);
    repeat (200) @(posedge clk);
    enMask[5] = 1'b0;
    rdChk(touch_key_pkg::ADDR_ENABLED, 32'(enMask), "en");
    waitScan(2);
    keySig[3] <= BASE - 12'h00B;
    waitKey(3, 1'b1, 4000);
    check("fastRun", 32'h5, 32'(maxRun));
    check("keyDetect", 32'h8, 32'(keyDetect));
    rdChk(touch_key_pkg::ADDR_DETECT, 32'h8, "detReg");
    bus(1'b1, 7'h04, CFG | 32'h4000_0000);
    bus(1'b1, 7'h08, CFG | 32'h4000_0008);
    keySig[1] <= BASE - 12'h014;
    keySig[2] <= BASE - 12'h019;
    waitKey(2, 1'b1, 4000);
    waitScan(2);
    check("keyDetect", 32'hC, 32'(keyDetect));
    keySig[1] <= BASE;
    keySig[2] <= BASE;
    waitKey(3, 1'b0, 12000);
    waitScan(2);
    check("keyDetect", 32'h0, 32'(keyDetect));
    keySig[3] <= BASE;
    bus(1'b1, 7'h0C, CFG ^ 32'h0000_4000);
    repeat (3000) @(posedge clk);
    waitScan(1);
    keySig[3] <= BASE - 12'h00B;
    waitKey(3, 1'b1, 4000);
    check("fastRun", 32'h1, 32'(maxRun));
    stopTest();
  end
endmodule
`default_nettype wire
